// ==== hdl/pvt_pkg.sv ====
package pvt_pkg;
	// ==========================================
	// Register word indices, byte address = 4*idx
	localparam logic [4:0] R_MODE      = 5'h00;
	localparam logic [4:0] R_CTRL      = 5'h01;
	localparam logic [4:0] R_CFG       = 5'h02;
	localparam logic [4:0] R_PROFILE   = 5'h03;
	localparam logic [4:0] R_TGT_VEL   = 5'h04;
	localparam logic [4:0] R_VEL_OFS   = 5'h05;
	localparam logic [4:0] R_VEL_WIN   = 5'h06;
	localparam logic [4:0] R_VEL_WIN_T = 5'h07;
	localparam logic [4:0] R_VEL_THR   = 5'h08;
	localparam logic [4:0] R_VEL_THR_T = 5'h09;
	localparam logic [4:0] R_MAX_PVEL  = 5'h0a;
	localparam logic [4:0] R_MAX_MSPD  = 5'h0b;
	localparam logic [4:0] R_PACC      = 5'h0c;
	localparam logic [4:0] R_PDEC      = 5'h0d;
	localparam logic [4:0] R_QSDEC     = 5'h0e;
	localparam logic [4:0] R_JERK      = 5'h0f;
	localparam logic [4:0] R_MAX_SLIP  = 5'h10;
	localparam logic [4:0] R_SLIP_T    = 5'h11;
	localparam logic [4:0] R_TGT_TRQ   = 5'h12;
	localparam logic [4:0] R_MAX_TRQ   = 5'h13;
	localparam logic [4:0] R_MAX_CUR   = 5'h14;
	localparam logic [4:0] R_TRQ_SLOPE = 5'h15;
	localparam logic [4:0] R_TRQ_OFS   = 5'h16;
	localparam logic [4:0] R_TRQ_WIN   = 5'h17;
	localparam logic [4:0] R_TRQ_WIN_T = 5'h18;
	localparam logic [4:0] R_MOT_CUR   = 5'h19;
	localparam logic [4:0] R_STATUS    = 5'h1a;
	localparam logic [4:0] R_VEL_DEM   = 5'h1b;
	localparam logic [4:0] R_VEL_ACT   = 5'h1c;
	localparam logic [4:0] R_TRQ_DEM   = 5'h1d;
	localparam logic [4:0] R_TRQ_ACT   = 5'h1e;
	localparam int         NREG        = 31;
	localparam logic [31:0] REG_RST    = 32'h0000_0000;
	// ==========================================
	// Field positions and codes
	localparam int B_OPEN    = 0;  // CTRL: operation enabled
	localparam int B_QSTOP   = 2;  // CTRL: quick stop
	localparam int B_HALT    = 8;  // CTRL: halt
	localparam int B_CLOSED  = 0;  // CFG: closed loop
	localparam int B_SUBMODE = 5;  // CFG: real torque submode
	localparam int B_POL     = 6;  // CFG: speed polarity
	localparam int B_REACHED = 10; // STATUS
	localparam int B_LIMIT   = 11;
	localparam int B_ZERO    = 12;
	localparam int B_DEV     = 13;
	localparam logic [7:0] MODE_PV    = 8'h03;
	localparam logic [7:0] MODE_PT    = 8'h04;
	localparam logic [1:0] PROF_JERK  = 2'h3;
	// ==========================================
	// Timing: one ramp tick per millisecond
	localparam int CLK_NS   = 20;
	localparam int TICK_NS  = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam logic [31:0] TICKS_PER_S = 32'h0000_03e8;
	// ==========================================
	// Types
	typedef enum logic [1:0] {
		RUN_OFF = 2'b00,
		RUN_PV  = 2'b01,
		RUN_PT  = 2'b10
	} run_t;
	typedef struct packed {
		logic signed [31:0] vel_act;
		logic signed [31:0] trq_act;
		logic signed [31:0] slip;
	} meas_t;
	typedef struct packed {
		logic signed [31:0] vel_dem;
		logic signed [31:0] trq_dem;
		logic signed [31:0] speed_lim;
		logic               speed_lim_en;
		logic               field_weak_en;
	} drive_t;
endpackage

// ==== hdl/pvt_modes.sv ====
// Overview of operation
// (RULE1) Mode value 3 selects profile velocity
// (RULE2) Halt stops; release ramps to target
// (RULE3) Velocity mode: reached bit plus halt
// (RULE4) Speed reached after window dwell time
// (RULE5) Zero speed clears above threshold time
// (RULE6) Closed loop slip timeout flags deviation
// (RULE7) Polarity bit six negates target speed
// (RULE8) Profile 0 trapezoid, 3 jerk limited
// (RULE9) Speed limit is smaller maximum
// (RULE10) Ramp output published as velocity demand
// (RULE11) Operation enabled ramps within all limits
// (RULE12) Accel, decel and quick stop rates
// (RULE13) Velocity offset added to setpoint
// (RULE14) Mode value 4 selects profile torque
// (RULE15) Torque halt stops, release restarts
// (RULE16) Torque reached after window dwell time
// (RULE17) Torque mode: reached bit plus halt
// (RULE18) Limit bit when target above max
// (RULE19) Torque units in permille of rated
// (RULE20) Torque clamped by current limits
// (RULE21) Torque slope bounds demand change
// (RULE22) Submode bit picks limited or real
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Dwell timer: condition held for lim ticks
module pvt_dwell (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        tick,
	input  wire logic        cond,
	input  wire logic [15:0] lim,
	output logic             hit
);
	logic [15:0] cnt; // Ticks with cond held

	// Count while held, restart on drop
	always_ff @(posedge clk) begin
		if (!rst_n || !cond) begin
			cnt <= 16'h0000;
		end else if (tick && cnt != 16'hffff) begin
			cnt <= cnt + 16'h0001;
		end
	end

	assign hit = cond && (cnt >= lim);
endmodule // pvt_dwell

// ==========================================
// Profile velocity and torque modes
module pvt_modes import pvt_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire meas_t       MEAS,
	output drive_t           DRIVE
);
	// ==========================================
	// Helpers
	function automatic logic signed [31:0] mag(
		input logic signed [31:0] v);
		return (v < 0) ? -v : v;
	endfunction

	function automatic logic signed [31:0] clamp(
		input logic signed [31:0] v,
		input logic signed [31:0] l);
		if (v > l) return l;
		if (v < -l) return -l;
		return v;
	endfunction

	// Per-tick step from a per-second rate
	function automatic logic signed [31:0] step(
		input logic [31:0] rate);
		logic [31:0] q;
		q = rate / TICKS_PER_S;
		if (q == 32'h0 && rate != 32'h0) q = 32'h1;
		return $signed(q);
	endfunction

	// One step of a ramp toward r
	function automatic logic signed [31:0] ramp(
		input logic signed [31:0] c,
		input logic signed [31:0] r,
		input logic signed [31:0] s);
		logic signed [31:0] d;
		d = r - c;
		if (d > s) return c + s;
		if (d < -s) return c - s;
		return r;
	endfunction

	// ==========================================
	// APB register file
	logic [31:0] regs [NREG];  // Writable words
	logic [4:0]  idx;          // Word index
	logic        mapped;       // Address decodes
	logic        wr;           // Write access to a mapped word
	logic [31:0] rd_val;       // Read mux
	logic [31:0] stat;         // Status word

	assign idx    = PADDR[6:2];
	assign mapped = !PADDR[7] && (idx < 5'(NREG));
	assign wr     = PSEL && PENABLE && PWRITE && mapped;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;

	// Software writes; read-only words ignore writes
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < NREG; i++) begin
				regs[i] <= REG_RST;
			end
		end else if (wr && idx < R_STATUS) begin
			regs[idx] <= PWDATA;
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= rd_val;
		end
	end

	// ==========================================
	// Decoded controls
	logic [7:0]  mode;        // Operating mode selector
	logic        op_en;       // Operation enabled
	logic        halt;        // Halt bit
	logic        qstop;       // Quick stop
	logic        jerk_mode;   // Jerk limited profile
	logic        submode;     // Real torque control
	run_t        run;         // Active mode

	assign mode      = regs[R_MODE][7:0];
	assign op_en     = regs[R_CTRL][B_OPEN];
	assign halt      = regs[R_CTRL][B_HALT];
	assign qstop     = regs[R_CTRL][B_QSTOP];
	assign submode   = regs[R_CFG][B_SUBMODE];
	// Profile type field selects ramp shape
	assign jerk_mode = regs[R_PROFILE][1:0] == PROF_JERK; // see (RULE8)

	// Mode selection under operation enabled
	always_comb begin
		run = RUN_OFF;
		if (op_en && mode == MODE_PV) begin
			run = RUN_PV; // see (RULE1) see (RULE11)
		end else if (op_en && mode == MODE_PT) begin
			run = RUN_PT; // see (RULE14)
		end
	end

	// ==========================================
	// Millisecond tick
	logic [15:0] tick_cnt; // Divider count
	logic        tick;     // Ramp update strobe

	// Divide the clock down to the ramp rate
	always_ff @(posedge CLK) begin
		if (!RST_N || tick) begin
			tick_cnt <= 16'h0000;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
		end
	end

	assign tick = tick_cnt == 16'(TICK_CYCLES - 1);

	// ==========================================
	// Velocity set value
	logic signed [31:0] tv_pol;  // Target after polarity
	logic signed [31:0] tv_set;  // Target plus offset
	logic signed [31:0] vlim;    // Speed limit
	logic signed [31:0] vel_ref; // Ramp goal
	logic signed [31:0] vel_dem; // Ramp output
	logic signed [31:0] vstep;   // Step this tick
	logic signed [31:0] jacc;    // Jerk-limited step
	logic signed [31:0] next_jacc;
	logic               accel;   // Moving away from zero

	// Polarity, offset and limit on the target
	always_comb begin
		tv_pol = $signed(regs[R_TGT_VEL]);
		if (regs[R_CFG][B_POL]) begin
			tv_pol = -tv_pol; // see (RULE7)
		end
		tv_set = tv_pol + $signed(regs[R_VEL_OFS]); // see (RULE13)
		vlim = $signed(regs[R_MAX_PVEL]);
		if ($signed(regs[R_MAX_MSPD]) < vlim) begin
			vlim = $signed(regs[R_MAX_MSPD]); // see (RULE9)
		end
	end

	// Goal is zero while halted or stopping
	always_comb begin
		vel_ref = 32'sh0;
		if (run == RUN_PV && !halt && !qstop) begin
			vel_ref = clamp(tv_set, vlim); // see (RULE2)
		end
	end

	// Rate chosen by ramp direction
	always_comb begin
		accel = (vel_dem >= 0 && vel_ref > vel_dem) ||
			(vel_dem <= 0 && vel_ref < vel_dem);
		if (qstop) begin
			vstep = step(regs[R_QSDEC]); // see (RULE12)
		end else if (accel) begin
			vstep = step(regs[R_PACC]); // see (RULE12)
		end else begin
			vstep = step(regs[R_PDEC]); // see (RULE12)
		end
		// Step grows by the jerk each tick
		next_jacc = jacc + step(regs[R_JERK]);
		if (vel_dem == vel_ref) begin
			next_jacc = 32'sh0;
		end else if (next_jacc > vstep) begin
			next_jacc = vstep;
		end
	end

	// Velocity ramp generator
	always_ff @(posedge CLK) begin
		if (!RST_N || run != RUN_PV) begin
			vel_dem <= 32'sh0;
			jacc    <= 32'sh0;
		end else if (tick && jerk_mode) begin
			jacc    <= next_jacc; // see (RULE8)
			vel_dem <= ramp(vel_dem, vel_ref, next_jacc);
		end else if (tick) begin
			vel_dem <= ramp(vel_dem, vel_ref, vstep); // see (RULE11)
		end
	end

	// ==========================================
	// Torque set value
	logic signed [31:0] tlim;    // Torque bound
	logic signed [31:0] trq_ref; // Ramp goal
	logic signed [31:0] trq_dem; // Ramp output
	logic               trq_over; // Target above max

	// Limits in permille of rated torque
	always_comb begin
		tlim = $signed(regs[R_MAX_TRQ]); // see (RULE19)
		if ($signed(regs[R_MAX_CUR]) < tlim) begin
			tlim = $signed(regs[R_MAX_CUR]); // see (RULE20)
		end
		if ($signed(regs[R_MOT_CUR]) < tlim) begin
			tlim = $signed(regs[R_MOT_CUR]); // see (RULE20)
		end
		trq_ref = 32'sh0;
		if (run == RUN_PT && !halt) begin
			trq_ref = clamp($signed(regs[R_TGT_TRQ]) +
				$signed(regs[R_TRQ_OFS]), tlim); // see (RULE15)
		end
		trq_over = mag($signed(regs[R_TGT_TRQ])) >
			$signed(regs[R_MAX_TRQ]); // see (RULE18)
	end

	// Torque ramp generator
	always_ff @(posedge CLK) begin
		if (!RST_N || run != RUN_PT) begin
			trq_dem <= 32'sh0;
		end else if (tick) begin
			trq_dem <= ramp(trq_dem, trq_ref,
				step(regs[R_TRQ_SLOPE])); // see (RULE21)
		end
	end

	// ==========================================
	// Status evaluation
	logic vel_in;   // Speed within window
	logic vel_ok;   // Held for window time
	logic trq_ok;   // Torque held in window
	logic moving;   // Speed above threshold time
	logic slip_err; // Slippage timed out

	assign vel_in = mag(MEAS.vel_act - vel_ref) <=
		$signed(regs[R_VEL_WIN]);

	pvt_dwell u_vel_win (
		.clk   (CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.cond  (vel_in),
		.lim   (regs[R_VEL_WIN_T][15:0]),
		.hit   (vel_ok)
	); // see (RULE4)

	pvt_dwell u_trq_win (
		.clk   (CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.cond  (mag(MEAS.trq_act - trq_ref) <=
			$signed(regs[R_TRQ_WIN])),
		.lim   (regs[R_TRQ_WIN_T][15:0]),
		.hit   (trq_ok)
	); // see (RULE16)

	pvt_dwell u_thr (
		.clk   (CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.cond  (mag(MEAS.vel_act) > $signed(regs[R_VEL_THR])),
		.lim   (regs[R_VEL_THR_T][15:0]),
		.hit   (moving)
	); // see (RULE5)

	// Strictly longer than the timeout
	pvt_dwell u_slip (
		.clk   (CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.cond  (regs[R_CFG][B_CLOSED] &&
			mag(MEAS.slip) > $signed(regs[R_MAX_SLIP])),
		.lim   (regs[R_SLIP_T][15:0] + 16'h0001),
		.hit   (slip_err)
	); // see (RULE6)

	// Status word assembly per active mode
	always_comb begin
		stat = 32'h0000_0000;
		stat[B_ZERO] = !moving; // see (RULE5)
		stat[B_DEV]  = slip_err; // see (RULE6)
		unique case (run)
			RUN_PV: begin
				stat[B_REACHED] = vel_ok; // see (RULE3)
			end
			RUN_PT: begin
				// Halted: standstill shown by speed
				stat[B_REACHED] = halt ? vel_ok : trq_ok; // see (RULE17)
				stat[B_LIMIT]   = trq_over; // see (RULE18)
			end
			RUN_OFF: begin
				stat[B_REACHED] = 1'b0;
			end
			default: begin
				stat[B_REACHED] = 1'b0;
			end
		endcase
	end

	// Read mux for words
	always_comb begin
		rd_val = 32'h0000_0000;
		if (idx < R_STATUS) rd_val = regs[idx];
		if (idx == R_STATUS) rd_val = stat;
		if (idx == R_VEL_DEM) rd_val = vel_dem; // see (RULE10)
		if (idx == R_VEL_ACT) rd_val = MEAS.vel_act; // see (RULE10)
		if (idx == R_TRQ_DEM) rd_val = trq_dem; // see (RULE21)
		if (idx == R_TRQ_ACT) rd_val = MEAS.trq_act;
		if (!mapped) rd_val = 32'h0000_0000;
	end

	// ==========================================
	// Drive outputs, registered
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DRIVE <= '0;
		end else begin
			DRIVE.vel_dem   <= vel_dem; // see (RULE10)
			DRIVE.trq_dem   <= trq_dem; // see (RULE21)
			DRIVE.speed_lim <= vlim;
			// Real torque has no speed limit or weakening
			DRIVE.speed_lim_en  <= !(run == RUN_PT && submode); // see (RULE22)
			DRIVE.field_weak_en <= run == RUN_PT && !submode; // see (RULE22)
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_rd_stat;
		PSEL && !PENABLE && !PWRITE && idx == R_STATUS;
	endsequence
	sequence s_rd_vdem;
		PSEL && !PENABLE && !PWRITE && idx == R_VEL_DEM;
	endsequence

	property p_off_zero;
		tick && run != RUN_PV |=> vel_dem == 0;
	endproperty
	a_off_zero: assert property (p_off_zero) // see (RULE1)
		else $error("velocity demand not zero outside mode");

	property p_halt_hold;
		run == RUN_PV && halt && vel_dem == 0 |=> vel_dem == 0;
	endproperty
	a_halt_hold: assert property (p_halt_hold) // see (RULE2)
		else $error("halted axis moved");

	property p_vlim;
		run == RUN_PV && mag(vel_dem) <= vlim && $stable(vlim)
			|=> mag(vel_dem) <= vlim;
	endproperty
	a_vlim: assert property (p_vlim) // see (RULE9)
		else $error("velocity demand above speed limit");

	property p_pol;
		$changed(regs[R_CFG][B_POL]) && $stable(regs[R_TGT_VEL])
			|-> tv_pol == -$past(tv_pol);
	endproperty
	a_pol: assert property (p_pol) // see (RULE7)
		else $error("polarity did not negate target");

	property p_slope;
		run == RUN_PT && $past(run) == RUN_PT |->
			mag(trq_dem - $past(trq_dem)) <=
			step($past(regs[R_TRQ_SLOPE]));
	endproperty
	a_slope: assert property (p_slope) // see (RULE21)
		else $error("torque demand changed faster than slope");

	property p_limit_rd;
		s_rd_stat ##1 1'b1 |->
			PRDATA[B_LIMIT] == $past(run == RUN_PT && trq_over);
	endproperty
	a_limit_rd: assert property (p_limit_rd) // see (RULE18)
		else $error("limit bit read wrong");

	property p_vdem_rd;
		s_rd_vdem ##1 1'b1 |-> PRDATA == $past(vel_dem);
	endproperty
	a_vdem_rd: assert property (p_vdem_rd) // see (RULE10)
		else $error("velocity demand read wrong");

	property p_zero;
		mag(MEAS.vel_act) <= $signed(regs[R_VEL_THR]) |-> stat[B_ZERO];
	endproperty
	a_zero: assert property (p_zero) // see (RULE5)
		else $error("zero speed bit clear below threshold");

	property p_dev_open;
		!regs[R_CFG][B_CLOSED] |-> !stat[B_DEV];
	endproperty
	a_dev_open: assert property (p_dev_open) // see (RULE6)
		else $error("deviation flagged in open loop");

	property p_reached;
		run == RUN_PV && stat[B_REACHED] |-> vel_in;
	endproperty
	a_reached: assert property (p_reached) // see (RULE4)
		else $error("reached while outside window");

	property p_submode;
		run == RUN_PT && submode |=> !DRIVE.field_weak_en;
	endproperty
	a_submode: assert property (p_submode) // see (RULE22)
		else $error("field weakening in real torque control");
endmodule // pvt_modes

`default_nettype wire

// ==== dv/pvt_plant.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Motor plant: actual values follow demand
module pvt_plant import pvt_pkg::*; (
	input  wire logic        clk,
	input  wire logic [31:0] slip_in,
	input  wire drive_t      drv,
	output meas_t            meas
);
	// Start from standstill
	initial meas = '0;

	// Ideal motor: one cycle lag, slip from bench
	always @(posedge clk) begin
		meas.vel_act <= drv.vel_dem;
		meas.trq_act <= drv.trq_dem;
		meas.slip    <= slip_in;
	end
endmodule // pvt_plant

`default_nettype wire

// ==== dv/profile_velocity_torque_modes_test.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Bench for profile velocity and torque modes
module profile_velocity_torque_modes_test import pvt_pkg::*;;
	logic        clk, rst_n, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, slip_in, q;
	logic        pready, pslverr, e;
	meas_t       meas;
	drive_t      drv;
	int          errors, check_count;
	logic signed [31:0] pv, pt;
	int          d, vmax, vfirst, tmax;

	// Short tick keeps the run brief
	pvt_modes #(.TICK_CYCLES(10)) u_dut (
		.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.MEAS(meas), .DRIVE(drv));

	pvt_plant u_plant (.clk(clk), .slip_in(slip_in), .drv(drv),
		.meas(meas));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========================================
	// Ramp step monitor: largest and first step
	always @(posedge clk) begin
		if (drv.vel_dem !== pv) begin
			d = int'(drv.vel_dem - pv);
			d = (d < 0) ? -d : d;
			if (d > vmax) vmax = d;
			if (vfirst == 0) vfirst = d;
		end
		if (drv.trq_dem !== pt) begin
			d = int'(drv.trq_dem - pt);
			d = (d < 0) ? -d : d;
			if (d > tmax) tmax = d;
		end
		pv = drv.vel_dem;
		pt = drv.trq_dem;
	end

	// ==========================================
	// Compare, verdict, bus tasks
	task automatic chk(input string n, input logic [31:0] s, x);
		check_count++;
		if (s !== x) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, x, s);
		end
	endtask

	task automatic test_done();
		if (errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [4:0] i,
		input logic [31:0] x);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {1'b0, i, 2'b00};
		pwdata  <= x;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 100) begin
			n++;
			@(posedge clk);
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [4:0] i, input logic [31:0] x);
		apb(1'b1, i, x);
	endtask

	// Read a register and compare it
	task automatic rc(input string n, input logic [4:0] i,
		input logic [31:0] x);
		apb(1'b0, i, 32'h0);
		chk(n, q, x);
	endtask

	// Read one status bit and compare it
	task automatic st(input string n, input int b, input logic x);
		apb(1'b0, R_STATUS, 32'h0);
		chk(n, 32'(q[b]), 32'(x));
	endtask

	task automatic tk(input int n);
		repeat (n * 10) @(posedge clk);
	endtask

	// Hang guard
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		test_done();
	end

	// ==========================================
	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		slip_in = 32'h0;
		vmax = 0;
		vfirst = 0;
		tmax = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc("mode", R_MODE, 32'h0);
		st("zero", B_ZERO, 1'b1);
		// Unmapped index and read-only write
		apb(1'b0, 5'h1f, 32'h0);
		chk("err", 32'(e), 32'h1);
		chk("unm", q, 32'h0);
		wr(R_VEL_DEM, 32'h0000_007b);
		rc("ro", R_VEL_DEM, 32'h0);
		// Speed limit is the smaller maximum
		wr(R_MAX_PVEL, 32'h0000_01f4);
		wr(R_MAX_MSPD, 32'h0000_012c);
		tk(1);
		chk("lim", drv.speed_lim, 32'h0000_012c);
		wr(R_MAX_PVEL, 32'h0000_0064);
		tk(1);
		chk("lim", drv.speed_lim, 32'h0000_0064);
		wr(R_MAX_PVEL, 32'h0000_01f4);
		// Velocity setup: steps 5 normal, 20 quick
		wr(R_PACC, 32'h0000_1388);
		wr(R_PDEC, 32'h0000_1388);
		wr(R_QSDEC, 32'h0000_4e20);
		wr(R_TGT_VEL, 32'h0000_001e);
		wr(R_VEL_OFS, 32'h0000_000a);
		wr(R_VEL_WIN, 32'h0000_0002);
		wr(R_VEL_WIN_T, 32'h0000_0003);
		wr(R_VEL_THR, 32'h0000_0014);
		wr(R_VEL_THR_T, 32'h0000_0002);
		wr(R_MAX_SLIP, 32'h0000_0005);
		wr(R_SLIP_T, 32'h0000_0002);
		wr(R_CTRL, 32'h0000_0001);
		tk(5);
		chk("off", drv.vel_dem, 32'h0);
		vmax = 0;
		vfirst = 0;
		wr(R_MODE, 32'(MODE_PV));
		tk(15);
		chk("vdem", drv.vel_dem, 32'h0000_0028);
		chk("vfst", 32'(vfirst), 32'h5);
		chk("vacc", 32'(vmax), 32'h5);
		rc("rdem", R_VEL_DEM, 32'h0000_0028);
		rc("ract", R_VEL_ACT, 32'h0000_0028);
		st("reach", B_REACHED, 1'b1);
		st("zero", B_ZERO, 1'b0);
		// Halt: braking, then standstill
		vmax = 0;
		wr(R_CTRL, 32'h0000_0101);
		tk(2);
		st("brake", B_REACHED, 1'b0);
		tk(15);
		chk("halt", drv.vel_dem, 32'h0);
		st("still", B_REACHED, 1'b1);
		st("zero", B_ZERO, 1'b1);
		chk("vdec", 32'(vmax), 32'h5);
		wr(R_CTRL, 32'h0000_0001);
		tk(15);
		chk("rel", drv.vel_dem, 32'h0000_0028);
		// Quick stop uses the fast ramp
		vmax = 0;
		wr(R_CTRL, 32'h0000_0005);
		tk(8);
		chk("qs", drv.vel_dem, 32'h0);
		chk("qstp", 32'(vmax), 32'h0000_0014);
		wr(R_CTRL, 32'h0000_0001);
		wr(R_CFG, 32'h0000_0040);
		tk(20);
		chk("pol", drv.vel_dem, 32'hffff_ffec);
		// Slip deviation only in closed loop
		slip_in <= 32'h0000_0064;
		wr(R_CFG, 32'h0000_0041);
		tk(5);
		st("dev", B_DEV, 1'b1);
		slip_in <= 32'h0;
		tk(1);
		st("dev", B_DEV, 1'b0);
		slip_in <= 32'h0000_0064;
		wr(R_CFG, 32'h0000_0040);
		tk(5);
		st("devo", B_DEV, 1'b0);
		slip_in <= 32'h0;
		// Jerk limited start
		wr(R_CTRL, 32'h0);
		wr(R_CFG, 32'h0);
		wr(R_PROFILE, 32'(PROF_JERK));
		wr(R_JERK, 32'h0000_03e8);
		tk(1);
		vfirst = 0;
		wr(R_CTRL, 32'h0000_0001);
		tk(30);
		chk("jfst", 32'(vfirst), 32'h1);
		chk("jdem", drv.vel_dem, 32'h0000_0028);
		// ==========================================
		// Torque mode
		wr(R_CTRL, 32'h0);
		wr(R_PROFILE, 32'h0);
		wr(R_MODE, 32'(MODE_PT));
		wr(R_MAX_TRQ, 32'h0000_00c8);
		wr(R_MAX_CUR, 32'h0000_0096);
		wr(R_MOT_CUR, 32'h0000_03e8);
		wr(R_TRQ_SLOPE, 32'h0000_2710);
		wr(R_TRQ_WIN, 32'h0000_0003);
		wr(R_TRQ_WIN_T, 32'h0000_0002);
		wr(R_TGT_TRQ, 32'h0000_012c);
		tmax = 0;
		wr(R_CTRL, 32'h0000_0001);
		tk(25);
		chk("tdem", drv.trq_dem, 32'h0000_0096);
		chk("tstp", 32'(tmax), 32'h0000_000a);
		st("tlim", B_LIMIT, 1'b1);
		st("treach", B_REACHED, 1'b1);
		chk("sle", 32'(drv.speed_lim_en), 32'h1);
		chk("fwe", 32'(drv.field_weak_en), 32'h1);
		wr(R_TGT_TRQ, 32'h0000_0064);
		wr(R_TRQ_OFS, 32'h0000_0014);
		tk(10);
		chk("tofs", drv.trq_dem, 32'h0000_0078);
		st("tlim", B_LIMIT, 1'b0);
		rc("rtdem", R_TRQ_DEM, 32'h0000_0078);
		rc("rtact", R_TRQ_ACT, 32'h0000_0078);
		wr(R_CFG, 32'h0000_0020);
		tk(1);
		chk("sle", 32'(drv.speed_lim_en), 32'h0);
		chk("fwe", 32'(drv.field_weak_en), 32'h0);
		wr(R_CTRL, 32'h0000_0101);
		tk(20);
		chk("thalt", drv.trq_dem, 32'h0);
		st("tstill", B_REACHED, 1'b1);
		wr(R_MOT_CUR, 32'h0000_0032);
		wr(R_CTRL, 32'h0000_0001);
		tk(15);
		chk("tmot", drv.trq_dem, 32'h0000_0032);
		test_done();
	end
endmodule // profile_velocity_torque_modes_test

`default_nettype wire
